// ==== design/cmvi_crossbar.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// selector-driven crossbar, pure combinational
// ----------------------------------------------------------------------------
module cmvi_crossbar import cmvi_pkg::*; #(
  parameter int unsigned NSRC = NUM_SRC,
  parameter int unsigned NDST = NUM_DST
) (
  input  wire logic [NSRC-1:0]       sources,
  input  wire logic [NDST*SEL_W-1:0] selectors,
  output logic      [NDST-1:0]       dests
);

  // field of destination k sits at bits 6k+5 down to 6k
  function automatic logic [SEL_W-1:0] selField(
    input logic [NDST*SEL_W-1:0] sel,
    input int unsigned           k
  );
    selField = sel[k*SEL_W +: SEL_W];
  endfunction

  // one 64-way multiplexer per destination, no state kept
  genvar k;
  generate
    for (k = 0; k < NDST; k++) begin : g_dst
      assign dests[k] = sources[selField(selectors, k)];
    end
  endgenerate

endmodule
`default_nettype wire

// ==== design/cmvi_matrix.sv ====
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - 64 sources, 96 destinations, one source each
// - six-bit selector per destination picks source
// - destination k uses bits 6k+5 to 6k
// - codes 32, 33: pins or virtual bits
// - codes 34 to 39: virtual bits 2-7
// - code 42 delay edge, 43 filter edge
// - codes 56-57 fast, 58-59 low-power comparators
// - code 46: power switch pin input
// - destinations 60, 62 switch; 61 unused
// - destinations 47-49 feed shared delay cell
// - plain cells: clock, data, low reset
// - counter cells 35-46: clock, reset, data
// - destinations 83-86: clock, reset, set, data
// - virtual byte at serial address 0x4C
// - writes set dedicated virtual levels immediately
// - reads return start-up or last value
// - bit 2032 picks pins or virtual bits
// - serial mode: pin0 clock, pin1 data
// - shared bits written like dedicated ones
module cmvi_matrix import cmvi_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
  input  wire logic                             sys_clk,
  input  wire logic                             rst,
  input  wire logic [CFG_W-1:0]                 configBits,
  input  wire logic [NUM_SRC-1:0]               sourceLines,
  input  wire logic                             delayEdgeOut,
  input  wire logic                             filterEdgeOut,
  input  wire logic                             powerSwitchCtrl0In,
  input  wire logic                             fastComparator0,
  input  wire logic                             fastComparator1,
  input  wire logic                             lowPowerComparator0,
  input  wire logic                             lowPowerComparator1,
  input  wire logic                             pin0In,
  input  wire logic                             pin1In,
  output logic                                  pin1Out,
  output logic                                  pin1OeN,
  output logic      [NUM_DST-1:0]               destLines,
  output logic                                  powerSwitchCtrl0,
  output logic                                  powerSwitchCtrl1,
  output cmvi_plain3_t   [NUM_PLAIN-1:0]        plainCells,
  output cmvi_counter3_t [NUM_COUNTER-1:0]      counterCells,
  output cmvi_shared3_t                         sharedDelayCell,
  output cmvi_counter4_t                        counterCell4
);

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic [NUM_SRC-1:0]       srcRaw;
  logic [NUM_SRC-1:0]       srcSync;
  logic [NUM_SRC-1:0]       srcMux;
  logic [1:0]               pinSync;
  logic [NUM_DST-1:0]       xbarOut;
  logic                     i2cMode;
  logic                     sclS;
  logic                     sdaS;
  logic                     sclPrevReg;
  logic                     sdaPrevReg;
  logic                     sclRise;
  logic                     sclFall;
  logic                     startSeen;
  logic                     stopSeen;
  cmvi_state_t              stateReg;
  cmvi_state_t              ackNextReg;
  logic [3:0]               bitCntReg;
  logic [7:0]               shiftReg;
  logic [7:0]               ptrReg;
  logic [7:0]               readData;
  logic                     virtWrite;
  logic [7:0]               virtualInputByte_reg;
  logic                     loadedReg;
  logic [7:0]               nvmImage;

  // --------------------------------------------------------------------------
  // source assembly and synchronisation
  // --------------------------------------------------------------------------
  assign i2cMode  = configBits[I2C_SEL_BIT];
  assign nvmImage = configBits[VIRT_NVM_LSB +: 8];

  // named sources overlay the generic lines at their codes
  always_comb begin
    srcRaw                   = sourceLines;
    srcRaw[SRC_DELAY_EDGE]   = delayEdgeOut;
    srcRaw[SRC_FILTER_EDGE]  = filterEdgeOut;
    srcRaw[SRC_POWER_SW0_IN] = powerSwitchCtrl0In;
    srcRaw[SRC_FAST_CMP0]    = fastComparator0;
    srcRaw[SRC_FAST_CMP1]    = fastComparator1;
    srcRaw[SRC_LP_CMP0]      = lowPowerComparator0;
    srcRaw[SRC_LP_CMP1]      = lowPowerComparator1;
  end

  // every external source is asynchronous to sys_clk
  cmvi_sync #(
    .WIDTH   (NUM_SRC)
  ) u_src_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn (srcRaw),
    .syncOut (srcSync)
  );

  // pin0 doubles as bus clock, pin1 as bus data
  cmvi_sync #(
    .WIDTH   (2)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn ({pin1In, pin0In}),
    .syncOut (pinSync)
  );

  // virtual bits replace codes 34..39, and 32..33 in serial mode; the register is already on sys_clk
  always_comb begin
    srcMux = srcSync;
    srcMux[SRC_PIN0_VIRT0] = i2cMode ? virtualInputByte_reg[0]
                                     : pinSync[0];
    srcMux[SRC_PIN1_VIRT1] = i2cMode ? virtualInputByte_reg[1]
                                     : pinSync[1];
    srcMux[SRC_VIRT2 +: NUM_DEDICATED] =
      virtualInputByte_reg[7:2];
  end

  cmvi_crossbar #(
    .NSRC      (NUM_SRC),
    .NDST      (NUM_DST)
  ) u_xbar (
    .sources   (srcMux),
    .selectors (configBits[NUM_DST*SEL_W-1:0]),
    .dests     (xbarOut)
  );

  // --------------------------------------------------------------------------
  // serial bus line tracking
  // --------------------------------------------------------------------------
  assign sclS = pinSync[0];
  assign sdaS = pinSync[1];

  // previous levels for edge finding, taken from synchronised copies
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclPrevReg <= 1'b1;
      sdaPrevReg <= 1'b1;
    end else begin
      sclPrevReg <= sclS;
      sdaPrevReg <= sdaS;
    end
  end

  assign sclRise   = sclS & ~sclPrevReg;
  assign sclFall   = ~sclS & sclPrevReg;
  // data moving while the clock is high marks frame start or stop
  assign startSeen = sclS & sclPrevReg & sdaPrevReg & ~sdaS;
  assign stopSeen  = sclS & sclPrevReg & ~sdaPrevReg & sdaS;

  // only the virtual input byte is mapped; other addresses read zero
  assign readData = (ptrReg == VIRT_BYTE_ADDR) ? virtualInputByte_reg
                                               : READ_UNMAPPED;

  // write strobe fires on the falling clock that ends the data byte
  assign virtWrite = i2cMode && (stateReg == ST_WRITE) && sclFall &&
                     (bitCntReg == BITS_PER_BYTE) &&
                     (ptrReg == VIRT_BYTE_ADDR);

  // --------------------------------------------------------------------------
  // serial slave state machine
  // --------------------------------------------------------------------------
  // sda only ever changes after a falling clock, so the master never sees
  // it move while scl is high
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stateReg   <= ST_IDLE;
      ackNextReg <= ST_IDLE;
      bitCntReg  <= 4'h0;
      shiftReg   <= 8'h00;
      ptrReg     <= 8'h00;
      pin1OeN    <= 1'b1;
    end else if (!i2cMode) begin
      // pins belong to the crossbar, the slave stays silent
      stateReg <= ST_IDLE;
      pin1OeN  <= 1'b1;
    end else if (startSeen) begin
      stateReg  <= ST_DEVADDR;
      bitCntReg <= 4'h0;
      pin1OeN   <= 1'b1;
    end else if (stopSeen) begin
      stateReg <= ST_IDLE;
      pin1OeN  <= 1'b1;
    end else begin
      case (stateReg)
        ST_DEVADDR, ST_PTR, ST_WRITE: begin
          if (sclRise && (bitCntReg < BITS_PER_BYTE)) begin
            shiftReg  <= {shiftReg[6:0], sdaS};
            bitCntReg <= bitCntReg + 4'h1;
          end else if (sclFall && (bitCntReg == BITS_PER_BYTE)) begin
            bitCntReg <= 4'h0;
            if (stateReg == ST_DEVADDR) begin
              if (shiftReg[7:1] == DEV_ADDR) begin
                pin1OeN    <= 1'b0;
                stateReg   <= ST_ACK;
                ackNextReg <= shiftReg[0] ? ST_READ : ST_PTR;
              end else begin
                stateReg <= ST_IDLE; // another slave is addressed
              end
            end else if (stateReg == ST_PTR) begin
              ptrReg     <= shiftReg;
              pin1OeN    <= 1'b0;
              stateReg   <= ST_ACK;
              ackNextReg <= ST_WRITE;
            end else begin
              // byte taken, pointer moves on for burst writes
              ptrReg     <= ptrReg + 8'h01;
              pin1OeN    <= 1'b0;
              stateReg   <= ST_ACK;
              ackNextReg <= ST_WRITE;
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            bitCntReg <= 4'h0;
            if (ackNextReg == ST_READ) begin
              shiftReg <= readData;
              pin1OeN  <= readData[7];
              ptrReg   <= ptrReg + 8'h01;
              stateReg <= ST_READ;
            end else begin
              pin1OeN  <= 1'b1;
              stateReg <= ackNextReg;
            end
          end
        end
        ST_READ: begin
          if (sclRise) begin
            bitCntReg <= bitCntReg + 4'h1;
          end else if (sclFall) begin
            if (bitCntReg == BITS_PER_BYTE) begin
              pin1OeN  <= 1'b1;
              stateReg <= ST_RDACK;
            end else begin
              shiftReg <= {shiftReg[6:0], 1'b0};
              pin1OeN  <= shiftReg[6];
            end
          end
        end
        ST_RDACK: begin
          // master low means acknowledge and another byte follows
          if (sclRise) begin
            if (sdaS) begin
              stateReg <= ST_IDLE;
            end else begin
              stateReg   <= ST_ACK;
              ackNextReg <= ST_READ;
            end
          end
        end
        ST_IDLE: begin
          pin1OeN <= 1'b1;
        end
        default: begin
          stateReg <= ST_IDLE;
          pin1OeN  <= 1'b1;
        end
      endcase
    end
  end

  // open-drain data pin only ever pulls low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin1Out <= 1'b0;
    end else begin
      pin1Out <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // virtual input byte
  // --------------------------------------------------------------------------
  // reset takes a constant; the start-up image is copied one edge after
  // release, before any bus write can have been decoded
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      loadedReg            <= 1'b0;
      virtualInputByte_reg <= VIRT_RESET;
    end else if (!loadedReg) begin
      loadedReg            <= 1'b1;
      virtualInputByte_reg <= nvmImage;
    end else if (virtWrite) begin
      virtualInputByte_reg <= shiftReg;
    end
  end

  // --------------------------------------------------------------------------
  // destination registers and typed views
  // --------------------------------------------------------------------------
  // outputs are registered, costing one cycle after the crossbar
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      destLines        <= '0;
      powerSwitchCtrl0 <= 1'b0;
      powerSwitchCtrl1 <= 1'b0;
    end else begin
      destLines               <= xbarOut;
      destLines[DST_RESERVED] <= 1'b0;
      powerSwitchCtrl0        <= xbarOut[DST_POWER_SW0];
      powerSwitchCtrl1        <= xbarOut[DST_POWER_SW1];
    end
  end

  // cells are plain slices of the registered lines
  genvar i;
  generate
    for (i = 0; i < NUM_PLAIN; i++) begin : g_plain
      assign plainCells[i] = destLines[DST_PLAIN_BASE + 3*i +: 3];
    end
    for (i = 0; i < NUM_COUNTER; i++) begin : g_cnt
      assign counterCells[i] =
        destLines[DST_COUNTER_BASE + 3*i +: 3];
    end
  endgenerate

  assign sharedDelayCell = destLines[DST_SHARED_BASE +: 3];
  assign counterCell4    = destLines[DST_CELL4_BASE +: 4];

endmodule
`default_nettype wire

// ==== design/cmvi_pkg.sv ====
// ----------------------------------------------------------------------------
// shared constants and types of the routing matrix
// ----------------------------------------------------------------------------
package cmvi_pkg;

  // matrix geometry
  localparam int unsigned NUM_SRC = 64;
  localparam int unsigned NUM_DST = 96;
  localparam int unsigned SEL_W   = 6;
  localparam int unsigned CFG_W   = 2048;
  localparam int unsigned SYNC_STAGES = 2;

  // configuration bit positions
  localparam int unsigned VIRT_NVM_LSB = 608;  // start-up image of the byte
  localparam int unsigned I2C_SEL_BIT  = 2032; // 1: pins serve the serial bus

  // source codes
  localparam int unsigned SRC_PIN0_VIRT0   = 32;
  localparam int unsigned SRC_PIN1_VIRT1   = 33;
  localparam int unsigned SRC_VIRT2        = 34;
  localparam int unsigned NUM_DEDICATED    = 6;
  localparam int unsigned SRC_DELAY_EDGE   = 42;
  localparam int unsigned SRC_FILTER_EDGE  = 43;
  localparam int unsigned SRC_POWER_SW0_IN = 46;
  localparam int unsigned SRC_FAST_CMP0    = 56;
  localparam int unsigned SRC_FAST_CMP1    = 57;
  localparam int unsigned SRC_LP_CMP0      = 58;
  localparam int unsigned SRC_LP_CMP1      = 59;

  // destination numbers
  localparam int unsigned DST_PLAIN_BASE   = 8;
  localparam int unsigned NUM_PLAIN        = 9;
  localparam int unsigned DST_COUNTER_BASE = 35;
  localparam int unsigned NUM_COUNTER      = 4;
  localparam int unsigned DST_SHARED_BASE  = 47;
  localparam int unsigned DST_CELL4_BASE   = 83;
  localparam int unsigned DST_POWER_SW0    = 60;
  localparam int unsigned DST_RESERVED     = 61;
  localparam int unsigned DST_POWER_SW1    = 62;

  // serial register side
  localparam logic [7:0] VIRT_BYTE_ADDR = 8'h4C;
  localparam logic [7:0] VIRT_RESET     = 8'h00;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [6:0] DEV_ADDR_DEF   = 7'h2A; // arbitrary value

  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_DEVADDR = 7'h02,
    ST_PTR     = 7'h04,
    ST_WRITE   = 7'h08,
    ST_ACK     = 7'h10,
    ST_READ    = 7'h20,
    ST_RDACK   = 7'h40
  } cmvi_state_t;

  // cell input groups, lowest destination in the lowest bit
  typedef struct packed {
    logic rstSetN;
    logic data;
    logic clk;
  } cmvi_plain3_t;

  typedef struct packed {
    logic data;
    logic rstSet;
    logic clk;
  } cmvi_counter3_t;

  typedef struct packed {
    logic clk;
    logic strobeOrRst;
    logic upOrIn;
  } cmvi_shared3_t;

  typedef struct packed {
    logic data;
    logic set;
    logic rst;
    logic clk;
  } cmvi_counter4_t;

endpackage

// ==== design/cmvi_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// two-stage level synchroniser, one chain per bit
// ----------------------------------------------------------------------------
module cmvi_sync import cmvi_pkg::*; #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1Reg;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1Reg <= '0;
      syncOut   <= '0;
    end else begin
      stage1Reg <= asyncIn;
      syncOut   <= stage1Reg;
    end
  end

endmodule
`default_nettype wire

// ==== design/unused_placeholder_none.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== verif/cmvi_i2c_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// serial host: drives the clock pin and pulls the data pin
// ------------------------------------------------------------------
module cmvi_i2c_host (
  output logic     scl,
  output logic     sdaOut,
  input  wire logic sda
);
  // both lines idle high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sdaOut = 1'b1;
  end

  // one bit: low 28 ns, high 20 ns; data moves mid-way in the low phase
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    #16;
    sdaOut = b;
    #12;
    scl = 1'b1;
    #10;
    r = sda;
    #10;
  endtask

  // s high: start, data falls under a high clock; s low: stop, it rises
  task automatic frame(input logic s);
    scl = 1'b0;
    #16;
    sdaOut = s;
    #12;
    scl = 1'b1;
    #20;
    sdaOut = ~s;
    #20;
  endtask

  // byte frame, msb first, then the acknowledge slot
  task automatic io(input logic [7:0] d, input logic ackIn,
                    output logic [7:0] q, output logic ackOut);
    int i;
    for (i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ackIn, ackOut);
  endtask
endmodule
`default_nettype wire

// ==== verif/cmvi_matrix_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// port checker of the routing matrix
// ------------------------------------------------------------------
module cmvi_matrix_chk import cmvi_pkg::*; (
  input wire logic                             sys_clk,
  input wire logic                             rst,
  input wire logic [CFG_W-1:0]                 configBits,
  input wire logic                             delayEdgeOut,
  input wire logic                             fastComparator0,
  input wire logic                             lowPowerComparator1,
  input wire logic                             pin0In,
  input wire logic                             pin1OeN,
  input wire logic [NUM_DST-1:0]               destLines,
  input wire logic                             powerSwitchCtrl0,
  input wire logic                             powerSwitchCtrl1,
  input wire cmvi_plain3_t   [NUM_PLAIN-1:0]   plainCells,
  input wire cmvi_counter3_t [NUM_COUNTER-1:0] counterCells,
  input wire cmvi_shared3_t                    sharedDelayCell,
  input wire cmvi_counter4_t                   counterCell4
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // route checks wait until the synchronisers have refilled
  logic [2:0] upCnt_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      upCnt_reg <= 3'h0;
    end else if (upCnt_reg != 3'h7) begin
      upCnt_reg <= upCnt_reg + 3'h1;
    end
  end
  wire logic settled = (upCnt_reg == 3'h7);

  chk_reserved_dest_zero: assert property (!destLines[61])
    else $error("reserved destination driven");
  chk_switch_ctrl_map: assert property (powerSwitchCtrl0 == destLines[60]
    && powerSwitchCtrl1 == destLines[62])
    else $error("switch control off its destination");
  chk_plain_cell_order: assert property (plainCells == destLines[34:8])
    else $error("plain cell order");
  chk_counter_cell_order: assert property (counterCells == destLines[46:35])
    else $error("counter cell order");
  chk_shared_cell_order: assert property (sharedDelayCell == destLines[49:47])
    else $error("shared cell order");
  chk_cell4_order: assert property (counterCell4 == destLines[86:83])
    else $error("four-input cell order");
  chk_delay_edge_route: assert property (settled && configBits[5:0] == 6'h2A
    |-> destLines[0] == $past(delayEdgeOut, 3))
    else $error("delay edge source not routed");
  chk_fast_cmp_route: assert property (settled && configBits[23:18] == 6'h38
    |-> destLines[3] == $past(fastComparator0, 3))
    else $error("fast comparator not routed");
  chk_slow_cmp_route: assert property (settled && configBits[41:36] == 6'h3B
    |-> destLines[6] == $past(lowPowerComparator1, 3))
    else $error("slow comparator not routed");
  chk_pin_mode_quiet: assert property (!configBits[I2C_SEL_BIT] |-> pin1OeN)
    else $error("data pin pulled outside serial mode");
  chk_pin0_route: assert property (settled && !configBits[I2C_SEL_BIT]
    && configBits[47:42] == 6'h20
    |-> destLines[7] == $past(pin0In, 3))
    else $error("pin not routed");
  chk_pull_stands: assert property ($fell(pin1OeN) |-> !pin1OeN [*4])
    else $error("pull too short");
endmodule

bind cmvi_matrix cmvi_matrix_chk cmvi_matrix_chk_i (
  .sys_clk             (sys_clk),
  .rst                 (rst),
  .configBits          (configBits),
  .delayEdgeOut        (delayEdgeOut),
  .fastComparator0     (fastComparator0),
  .lowPowerComparator1 (lowPowerComparator1),
  .pin0In              (pin0In),
  .pin1OeN             (pin1OeN),
  .destLines           (destLines),
  .powerSwitchCtrl0    (powerSwitchCtrl0),
  .powerSwitchCtrl1    (powerSwitchCtrl1),
  .plainCells          (plainCells),
  .counterCells        (counterCells),
  .sharedDelayCell     (sharedDelayCell),
  .counterCell4        (counterCell4)
);
`default_nettype wire

// ==== verif/cmvi_matrix_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmvi_matrix_tb import cmvi_pkg::*;;
  // ------------------------------------------------------------------
  // wiring
  // ------------------------------------------------------------------
  localparam logic [7:0] START_VAL = 8'hA5;
  localparam logic [5:0] SEL_TAB [16] = '{6'h2A, 6'h2B, 6'h2E, 6'h38,
    6'h39, 6'h3A, 6'h3B, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25,
    6'h26, 6'h27, 6'h05};
  logic                    sys_clk;
  logic                    rst;
  logic                    serial;
  logic [CFG_W-1:0]        configBits;
  logic [NUM_SRC-1:0]      sourceLines;
  logic [6:0]              sideIn;
  logic                    pinDrv0;
  logic                    pinDrv1;
  wire logic               scl;
  wire logic               hostSda;
  wire logic               sda;
  wire logic               pin1Out;
  wire logic               pin1OeN;
  wire logic [NUM_DST-1:0] destLines;
  wire logic               powerSwitchCtrl0;
  wire logic               powerSwitchCtrl1;
  int                      bad_count;
  int                      total_checks;

  // open-drain data line: released means pulled high
  assign sda = hostSda & (pin1OeN ? 1'b1 : pin1Out);

  cmvi_matrix #(.DEV_ADDR(DEV_ADDR_DEF)) cmvi_matrix_i (
    .sys_clk             (sys_clk),
    .rst                 (rst),
    .configBits          (configBits),
    .sourceLines         (sourceLines),
    .delayEdgeOut        (sideIn[0]),
    .filterEdgeOut       (sideIn[1]),
    .powerSwitchCtrl0In  (sideIn[2]),
    .fastComparator0     (sideIn[3]),
    .fastComparator1     (sideIn[4]),
    .lowPowerComparator0 (sideIn[5]),
    .lowPowerComparator1 (sideIn[6]),
    .pin0In              (serial ? scl : pinDrv0),
    .pin1In              (serial ? sda : pinDrv1),
    .pin1Out             (pin1Out),
    .pin1OeN             (pin1OeN),
    .destLines           (destLines),
    .powerSwitchCtrl0    (powerSwitchCtrl0),
    .powerSwitchCtrl1    (powerSwitchCtrl1),
    .plainCells          (),
    .counterCells        (),
    .sharedDelayCell     (),
    .counterCell4        ()
  );

  cmvi_i2c_host cmvi_i2c_host_i (
    .scl    (scl),
    .sdaOut (hostSda),
    .sda    (sda)
  );

  // 200 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // configuration changes only under reset
  task automatic do_reset(input logic s);
    logic [CFG_W-1:0] c;
    int k;
    c = '0;
    for (k = 0; k < 16; k++) begin
      c[k*6 +: 6] = SEL_TAB[k];
    end
    c[360 +: 12] = 12'hFFF;
    c[VIRT_NVM_LSB +: 8] = START_VAL;
    c[I2C_SEL_BIT] = s;
    @(posedge sys_clk);
    rst <= 1'b1;
    configBits <= c;
    serial <= s;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    settle(8);
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [15:0] d,
                    input int n);
    logic [7:0] q;
    logic a;
    int i;
    cmvi_i2c_host_i.frame(1'b1);
    cmvi_i2c_host_i.io({DEV_ADDR_DEF, 1'b0}, 1'b1, q, a);
    cmp8({7'h00, a}, 8'h00);
    cmvi_i2c_host_i.io(ptr, 1'b1, q, a);
    for (i = n - 1; i >= 0; i--) begin
      cmvi_i2c_host_i.io(d[i*8 +: 8], 1'b1, q, a);
      cmp8({7'h00, a}, 8'h00);
    end
    cmvi_i2c_host_i.frame(1'b0);
  endtask

  // reads the byte at ptr, then its neighbour
  task automatic rd(input logic [7:0] ptr, output logic [15:0] v);
    logic [7:0] q;
    logic a;
    cmvi_i2c_host_i.frame(1'b1);
    cmvi_i2c_host_i.io({DEV_ADDR_DEF, 1'b0}, 1'b1, q, a);
    cmvi_i2c_host_i.io(ptr, 1'b1, q, a);
    cmvi_i2c_host_i.frame(1'b1);
    cmvi_i2c_host_i.io({DEV_ADDR_DEF, 1'b1}, 1'b1, q, a);
    cmp8({7'h00, a}, 8'h00);
    cmvi_i2c_host_i.io(8'hFF, 1'b0, v[15:8], a);
    cmvi_i2c_host_i.io(8'hFF, 1'b1, v[7:0], a);
    cmvi_i2c_host_i.frame(1'b0);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_serial;
    logic [15:0] v;
    logic [7:0] q;
    logic a;
    do_reset(1'b1);
    cmp8(destLines[14:7], START_VAL);
    rd(8'h4C, v);
    cmp8(v[15:8], START_VAL);
    cmp8(v[7:0], READ_UNMAPPED);
    wr(8'h4C, 16'h003C, 1);
    settle(4);
    cmp8(destLines[14:7], 8'h3C);
    // burst: unmapped byte, then the mapped one
    wr(8'h4B, 16'hFF5A, 2);
    settle(4);
    cmp8(destLines[14:7], 8'h5A);
    rd(8'h4C, v);
    cmp8(v[15:8], 8'h5A);
    cmvi_i2c_host_i.frame(1'b1);
    cmvi_i2c_host_i.io({DEV_ADDR_DEF ^ 7'h01, 1'b0}, 1'b1, q, a);
    cmp8({7'h00, a}, 8'h01);
    cmvi_i2c_host_i.io(8'h4C, 1'b1, q, a);
    cmvi_i2c_host_i.io(8'h00, 1'b1, q, a);
    cmvi_i2c_host_i.frame(1'b0);
    settle(4);
    cmp8(destLines[14:7], 8'h5A);
    $display("test serial done");
  endtask

  task automatic t_direct;
    logic [6:0] pat [4] = '{7'h55, 7'h2A, 7'h7F, 7'h00};
    int i;
    for (i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      sideIn <= pat[i];
      sourceLines[5] <= pat[i][0];
      sourceLines[63] <= pat[i][1];
      settle(4);
      cmp8({1'b0, destLines[6:0]}, {1'b0, pat[i]});
      cmp8({5'h00, destLines[62:60]}, {7'h00, pat[i][1]});
      cmp8({7'h00, destLines[15]}, {7'h00, pat[i][0]});
    end
    $display("test direct done");
  endtask

  task automatic t_pins;
    int i;
    do_reset(1'b0);
    cmp8({2'h0, destLines[14:9]}, {2'h0, START_VAL[7:2]});
    for (i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      pinDrv0 <= i[0];
      pinDrv1 <= i[1];
      settle(4);
      cmp8({6'h00, destLines[8:7]}, {6'h00, i[1:0]});
      cmp8({7'h00, pin1OeN}, 8'h01);
    end
    $display("test pins done");
  endtask

  task automatic close_out;
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    serial = 1'b1;
    configBits = '0;
    sourceLines = '0;
    sideIn = '0;
    pinDrv0 = 1'b0;
    pinDrv1 = 1'b0;
    bad_count = 0;
    total_checks = 0;
    t_serial();
    t_direct();
    t_pins();
    close_out();
  end

  // a hang ends the run here
  initial begin
    #100000;
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out();
  end
endmodule
`default_nettype wire
